// File: bench/ext_pulse_src.sv
// Behavioural source of pulses on the external count input.
module ext_pulse_src (
   // Clock.
   input  wire logic clk_i,
   // Pin.
   output logic      pulse_o
);
   timeunit 1ns;
   timeprecision 1ns;
   initial pulse_o = 1'b0;
   // Levels of eight cycles or more keep the rate at fc/16 or below; the pin idles low.
   task automatic burst(input int n, input int w);
      repeat (n) begin
         pulse_o <= 1'b1;
         repeat (w) @(posedge clk_i);
         pulse_o <= 1'b0;
         repeat (w) @(posedge clk_i);
      end
   endtask : burst
endmodule : ext_pulse_src

// File: bench/gate_timer_unit_chk.sv
// Port-level assertions for the gate timer unit.
module gate_timer_unit_chk import tc_pkg::*; #(
   parameter int COUNT_WIDTH = 18
) (
   // Clock, reset and enable.
   input wire logic        CLK_I,
   input wire logic        RESETN_I,
   input wire logic        CE_I,
   // Bus.
   input wire logic        HSEL_I,
   input wire logic [31:0] HADDR_I,
   input wire logic [1:0]  HTRANS_I,
   input wire logic        HWRITE_I,
   input wire logic [31:0] HWDATA_I,
   input wire logic        HREADY_I,
   input wire logic [31:0] HRDATA_O,
   // Pins.
   input wire logic        COMPANION_PULSE_I,
   input wire logic        SHARED_PIN_O,
   input wire logic        SHARED_PIN_OE_O,
   input wire logic        TIMER_IRQ_O
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking cb @(posedge CLK_I); endclocking
   default disable iff (!RESETN_I);
   logic       dp_wr;
   logic [7:0] dp_idx;
   logic [1:0] mode_sh;
   logic       hold_cmp;
   wire        take = HSEL_I && HTRANS_I[1] && HREADY_I && CE_I;
   always_ff @(posedge CLK_I or negedge RESETN_I) begin
      if (!RESETN_I) begin
         dp_wr    <= 1'b0;
         dp_idx   <= 8'h00;
         mode_sh  <= RST_CONTROL_ONE[1:0];
         hold_cmp <= 1'b0;
      end else begin
         dp_wr  <= take && HWRITE_I;
         dp_idx <= HADDR_I[9:2];
         if (dp_wr && dp_idx == IDX_CONTROL_ONE)
            mode_sh <= HWDATA_I[1:0];
         if (dp_wr && (dp_idx == IDX_COMPARE_LOW || dp_idx == IDX_COMPARE_MID))
            hold_cmp <= 1'b1;
         else if (dp_wr && dp_idx == IDX_COMPARE_HIGH)
            hold_cmp <= 1'b0;
      end
   end
   sequence s_wr_ctl2;
      take && HWRITE_I && HADDR_I[9:2] == IDX_CONTROL_TWO;
   endsequence
   sequence s_rd(logic [7:0] idx);
      take && !HWRITE_I && HADDR_I[9:2] == idx;
   endsequence
   property p_route;
      logic b;
      s_wr_ctl2 ##1 (1'b1, b = HWDATA_I[POS_PWM_ROUTE_DIS]) |-> ##[1:2] (SHARED_PIN_OE_O == !b);
   endproperty
   a_irq_one_cycle: assert property (TIMER_IRQ_O |=> !TIMER_IRQ_O)
      else $error("timer request wider than one cycle");
   a_irq_ce_off: assert property (!$past(CE_I) |-> !TIMER_IRQ_O)
      else $error("timer request while frozen");
   a_pin_copy: assert property ($past(CE_I) && $past(RESETN_I) |-> SHARED_PIN_O == $past(COMPANION_PULSE_I))
      else $error("shared pin does not follow pulse");
   a_route_oe: assert property (p_route)
      else $error("pin enable does not follow route bit");
   a_status_zeros: assert property (s_rd(IDX_STATUS) |=> HRDATA_O[5:0] == 6'h00 && HRDATA_O[31:8] == 24'h000000)
      else $error("status low bits not zero");
   a_ctl2_bit0: assert property (s_rd(IDX_CONTROL_TWO) |=> !HRDATA_O[0])
      else $error("control two bit 0 not zero");
   a_gate_flag_idle: assert property (s_rd(IDX_STATUS) ##0 (mode_sh != MODE_FREQUENCY && $past(mode_sh) != MODE_FREQUENCY)
      |=> !HRDATA_O[POS_GATE_COUNTING])
      else $error("gate flag set outside frequency mode");
   // The one-cycle guard lets a match already in flight when the low byte landed still fire.
   a_hold_compare: assert property (hold_cmp && $past(hold_cmp) |-> !TIMER_IRQ_O)
      else $error("match while compare half written");
endmodule : gate_timer_unit_chk

bind gate_timer_unit gate_timer_unit_chk #(.COUNT_WIDTH(COUNT_WIDTH)) u_chk (
   .CLK_I(CLK_I), .RESETN_I(RESETN_I), .CE_I(CE_I), .HSEL_I(HSEL_I), .HADDR_I(HADDR_I),
   .HTRANS_I(HTRANS_I), .HWRITE_I(HWRITE_I), .HWDATA_I(HWDATA_I), .HREADY_I(HREADY_I), .HRDATA_O(HRDATA_O),
   .COMPANION_PULSE_I(COMPANION_PULSE_I), .SHARED_PIN_O(SHARED_PIN_O), .SHARED_PIN_OE_O(SHARED_PIN_OE_O),
   .TIMER_IRQ_O(TIMER_IRQ_O));

// File: bench/test_timer1_gate_and_event_counter.sv
// Self-checking testbench of the gate timer unit.
`define CHK(got, exp) begin compares++; if ((got) !== (exp)) begin n_fail++; $display("ERROR %0t got %0h expected %0h", $time, got, exp); end end
module test_timer1_gate_and_event_counter import tc_pkg::*; ;
   timeunit 1ns;
   timeprecision 1ns;
   logic        clk = 1'b0, rst_n = 1'b0, ce = 1'b1, hsel = 1'b0, hwrite = 1'b0, fs_clk = 1'b0;
   logic        comp = 1'b0, gate_drv = 1'b0, gate_lvl = 1'b0;
   logic [1:0]  htrans = 2'h0;
   logic [2:0]  hsize = 3'h2;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0, d;
   logic [7:0]  v;
   logic [1:0]  seen;
   wire  [31:0] hrdata;
   wire         hready, hresp, ext, pin, pin_oe, irq;
   int          n_fail = 0, compares = 0, n_irq = 0, i, n, k, c, e;
   gate_timer_unit #(.COUNT_WIDTH(18)) i_dut (
      .CLK_I(clk), .RESETN_I(rst_n), .CE_I(ce), .HSEL_I(hsel), .HADDR_I(haddr), .HTRANS_I(htrans),
      .HWRITE_I(hwrite), .HSIZE_I(hsize), .HWDATA_I(hwdata), .HREADY_I(hready), .HRDATA_O(hrdata),
      .HREADYOUT_O(hready), .HRESP_O(hresp), .EXT_COUNT_I(ext), .FS_CLK_I(fs_clk),
      .COMPANION_PULSE_I(comp), .SHARED_PIN_O(pin), .SHARED_PIN_OE_O(pin_oe), .TIMER_IRQ_O(irq));
   ext_pulse_src i_src (.clk_i(clk), .pulse_o(ext));
   always #20 clk = ~clk;
   always begin
      repeat (2) @(posedge clk);
      fs_clk <= ~fs_clk;
   end
   always @(posedge clk) comp <= gate_drv ? gate_lvl : 1'($urandom());
   always @(negedge clk) if (irq === 1'b1) n_irq++;
   task automatic close_out;
      $display("compares %0d n_fail %0d", compares, n_fail);
      if (n_fail == 0 && compares > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask : close_out
   initial begin
      #(40000 * 40);
      n_fail++;
      $display("ERROR %0t watchdog expired", $time);
      close_out();
   end
   task automatic xfer(input logic [7:0] idx, input logic wr, input logic [7:0] wd, output logic [31:0] rd);
      hsel   <= 1'b1;
      htrans <= 2'h2;
      haddr  <= {22'h0, idx, 2'b00};
      hwrite <= wr;
      do @(posedge clk); while (hready !== 1'b1);
      hsel   <= 1'b0;
      htrans <= 2'h0;
      hwdata <= {24'h0, wd};
      do @(posedge clk); while (hready !== 1'b1);
      rd = hrdata;
   endtask : xfer
   task automatic wr(input logic [7:0] idx, input logic [7:0] wd);
      logic [31:0] x;
      xfer(idx, 1'b1, wd, x);
   endtask : wr
   task automatic rd(input logic [7:0] idx, output logic [31:0] r);
      xfer(idx, 1'b0, 8'h00, r);
   endtask : rd
   task automatic set_compare(input logic [17:0] cv);
      wr(IDX_COMPARE_LOW, cv[7:0]);
      wr(IDX_COMPARE_MID, cv[15:8]);
      wr(IDX_COMPARE_HIGH, {6'h00, cv[17:16]});
   endtask : set_compare
   task automatic wait_irq(output int cnt);
      cnt = 0;
      do begin
         @(negedge clk);
         cnt++;
      end while (irq !== 1'b1 && cnt < 5000);
      @(posedge clk);
   endtask : wait_irq
   function automatic logic [7:0] ctl1(input logic run, input logic [2:0] sel, input logic [1:0] mode);
      return {1'b1, run, 1'b0, sel, mode};
   endfunction : ctl1
   // One gate period is two phases of one tick, a tick being 2^(4+code) fs edges of four cycles each.
   function automatic int exp_gate_irqs(input int code, input int both, input int span);
      return (code == 3) ? 0 : (span >> (7 + code)) * (both ? 2 : 1);
   endfunction : exp_gate_irqs
   initial begin
      void'($urandom(42));
      repeat (20) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      rd(IDX_CONTROL_TWO, d); `CHK(d, {24'h0, RST_CONTROL_TWO})
      rd(IDX_STATUS, d); `CHK(d, 32'h0)
      rd(8'h30, d); `CHK(d, 32'h0)
      `CHK(pin_oe, 1'b1)
      for (i = 0; i < 8; i++) begin
         v = 8'($urandom());
         v[1:0] = {i[0], 1'b0};
         wr(IDX_CONTROL_TWO, v);
         rd(IDX_CONTROL_TWO, d); `CHK(d, {24'h0, v})
         `CHK(pin_oe, ~v[1])
      end
      wr(IDX_CONTROL_TWO, 8'h00);
      for (i = 0; i < 3; i++) begin
         n = 3 + int'($urandom_range(37));
         wr(IDX_CONTROL_ONE, ctl1(1'b0, CLK_FC, MODE_TIMER_EVENT));
         wr(IDX_COMPARE_LOW, n[7:0]);
         wr(IDX_CONTROL_ONE, ctl1(1'b1, CLK_FC, MODE_TIMER_EVENT));
         k = n_irq;
         repeat (2 * n + 5) @(posedge clk);
         `CHK(n_irq - k, 0)
         wr(IDX_COMPARE_MID, 8'h00);
         wr(IDX_COMPARE_HIGH, 8'h00);
         // The count ran past the compare value while it was held, so restart it from zero.
         wr(IDX_CONTROL_ONE, ctl1(1'b0, CLK_FC, MODE_TIMER_EVENT));
         wr(IDX_CONTROL_ONE, ctl1(1'b1, CLK_FC, MODE_TIMER_EVENT));
         wait_irq(c);
         wait_irq(c); `CHK(c, n)
      end
      ce <= 1'b0;
      repeat (6) @(posedge clk);
      ce <= 1'b1;
      wait_irq(c);
      wait_irq(c); `CHK(c, n)
      wr(IDX_CONTROL_ONE, ctl1(1'b0, CLK_FC, MODE_TIMER_EVENT));
      wr(IDX_SYSTEM_MODE, 8'h01);
      set_compare(18'h00805);
      wr(IDX_CONTROL_ONE, ctl1(1'b1, CLK_FC, MODE_TIMER_EVENT));
      wait_irq(c);
      wait_irq(c); `CHK(c, 1 << SLOW_FC_IGNORED)
      wr(IDX_CONTROL_ONE, ctl1(1'b0, CLK_EXTERNAL, MODE_TIMER_EVENT));
      wr(IDX_SYSTEM_MODE, 8'h00);
      for (i = 0; i < 2; i++) begin
         n = 2 + int'($urandom_range(4));
         wr(IDX_CONTROL_ONE, ctl1(1'b0, CLK_EXTERNAL, MODE_TIMER_EVENT));
         set_compare(18'(n));
         wr(IDX_CONTROL_ONE, ctl1(1'b1, CLK_EXTERNAL, MODE_TIMER_EVENT));
         k = n_irq;
         i_src.burst(2 * n + 1, 8 + int'($urandom_range(4)));
         repeat (8) @(posedge clk);
         `CHK(n_irq - k, 2)
         rd(IDX_COMPARE_LOW, d); `CHK(d, 32'h1)
      end
      wr(IDX_CONTROL_ONE, ctl1(1'b0, CLK_EXTERNAL, MODE_FREQUENCY));
      wr(IDX_SYSTEM_MODE, 8'h02);
      wr(IDX_GATE_PERIOD, 8'hFF);
      for (i = 0; i < 4; i++) begin
         wr(IDX_CONTROL_ONE, ctl1(1'b0, CLK_EXTERNAL, MODE_FREQUENCY));
         wr(IDX_CONTROL_TWO, {3'h0, i[0], i[1:0], 2'h0});
         wr(IDX_CONTROL_ONE, ctl1(1'b1, CLK_EXTERNAL, MODE_FREQUENCY));
         k = n_irq;
         seen = 2'b00;
         repeat (128) begin
            repeat (14) @(posedge clk);
            rd(IDX_STATUS, d);
            seen[d[POS_GATE_COUNTING]] = 1'b1;
         end
         e = exp_gate_irqs(i, i % 2, 2048);
         c = n_irq - k;
         `CHK(c >= e - 1 && c <= e + 1, 1'b1)
         if (i < 3) `CHK(seen, 2'b11)
      end
      wr(IDX_CONTROL_ONE, ctl1(1'b0, CLK_EXTERNAL, MODE_FREQUENCY));
      gate_drv <= 1'b1;
      wr(IDX_CONTROL_TWO, 8'h30);
      wr(IDX_CONTROL_ONE, ctl1(1'b1, CLK_EXTERNAL, MODE_FREQUENCY));
      k = n_irq;
      repeat (4) begin
         gate_lvl <= 1'b1;
         repeat (20) @(posedge clk);
         gate_lvl <= 1'b0;
         repeat (20) @(posedge clk);
      end
      repeat (4) @(posedge clk);
      `CHK(n_irq - k, 8)
      close_out();
   end
endmodule : test_timer1_gate_and_event_counter

// File: common/tc_pkg.sv
// Register map, field positions, reset values and divider exponents of the gate timer unit.
package tc_pkg;
   // Register indices; the byte address is four times the index.
   localparam logic [7:0]  IDX_CONTROL_ONE     = 8'h14;
   localparam logic [7:0]  IDX_CONTROL_TWO     = 8'h15;
   localparam logic [7:0]  IDX_STATUS          = 8'h16;
   localparam logic [7:0]  IDX_COMPARE_LOW     = 8'h20;
   localparam logic [7:0]  IDX_COMPARE_MID     = 8'h21;
   localparam logic [7:0]  IDX_COMPARE_HIGH    = 8'h22;
   localparam logic [7:0]  IDX_GATE_PERIOD     = 8'h23;
   localparam logic [7:0]  IDX_SYSTEM_MODE     = 8'h24;
   // Reset values.
   localparam logic [7:0]  RST_CONTROL_ONE     = 8'h88;
   localparam logic [7:0]  RST_CONTROL_TWO     = 8'h00;
   localparam logic [7:0]  RST_GATE_PERIOD     = 8'h00;
   // Control one fields.
   localparam int          POS_CLEAR_CTRL      = 7;
   localparam int          POS_RUN_LSB         = 5;
   localparam int          POS_CLOCK_SEL_LSB   = 2;
   localparam int          POS_MODE_LSB        = 0;
   localparam logic [1:0]  RUN_START           = 2'h2;
   localparam logic [1:0]  MODE_TIMER_EVENT    = 2'h0;
   localparam logic [1:0]  MODE_FREQUENCY      = 2'h3;
   localparam logic [2:0]  CLK_EXTERNAL        = 3'h7;
   localparam logic [2:0]  CLK_FC              = 3'h0;
   // Control two fields.
   localparam int          POS_EXT_EDGE        = 7;
   localparam int          POS_GATE_SRC_LSB    = 5;
   localparam int          POS_GATE_IRQ_EDGE   = 4;
   localparam int          POS_GATE_CLK_LSB    = 2;
   localparam int          POS_PWM_ROUTE_DIS   = 1;
   localparam logic [1:0]  GATE_SRC_INTERNAL   = 2'h0;
   localparam logic [1:0]  GATE_CLK_RESERVED   = 2'h3;
   // Status fields.
   localparam int          POS_GATE_COUNTING   = 7;
   localparam int          POS_OVERFLOW        = 6;
   // System mode fields.
   localparam int          POS_SLOW_MODE       = 0;
   localparam int          POS_DIVIDER_SRC     = 1;
   // Divider exponents for the count and gate clocks.
   localparam logic [4:0]  EXP_FC_23           = 5'd23;
   localparam logic [4:0]  EXP_FC_13           = 5'd13;
   localparam logic [4:0]  EXP_FC_12           = 5'd12;
   localparam logic [4:0]  EXP_FC_11           = 5'd11;
   localparam logic [4:0]  EXP_FC_7            = 5'd7;
   localparam logic [4:0]  EXP_FC_3            = 5'd3;
   localparam logic [4:0]  EXP_FS_15           = 5'd15;
   localparam logic [4:0]  EXP_FS_5            = 5'd5;
   localparam logic [4:0]  EXP_FS_4            = 5'd4;
   localparam logic [4:0]  EXP_FS_3            = 5'd3;
   // Number of low compare bits ignored when fc drives timer mode in slow mode; bits 17 down to this one still count.
   localparam int          SLOW_FC_IGNORED     = 11;
   localparam logic [4:0]  GATE_PERIOD_BASE    = 5'd16;
endpackage : tc_pkg

// File: rtl/gate_timer_unit.sv
// Timer and event counter with window gate, control register two and status register behind AHB-Lite.
//
// Chosen here: the AHB-Lite slave port.
module gate_timer_unit #(
   parameter int COUNT_WIDTH = 18
) (
   // Clock, reset and clock enable.
   input  wire logic        CLK_I,
   input  wire logic        RESETN_I,
   input  wire logic        CE_I,
   // AHB-Lite slave.
   input  wire logic        HSEL_I,
   input  wire logic [31:0] HADDR_I,
   input  wire logic [1:0]  HTRANS_I,
   input  wire logic        HWRITE_I,
   input  wire logic [2:0]  HSIZE_I,
   input  wire logic [31:0] HWDATA_I,
   input  wire logic        HREADY_I,
   output logic      [31:0] HRDATA_O,
   output logic             HREADYOUT_O,
   output logic             HRESP_O,
   // Pins and neighbouring logic.
   input  wire logic        EXT_COUNT_I,
   input  wire logic        FS_CLK_I,
   input  wire logic        COMPANION_PULSE_I,
   output logic             SHARED_PIN_O,
   output logic             SHARED_PIN_OE_O,
   output logic             TIMER_IRQ_O
);
   import tc_pkg::*;

   // The compare byte lanes are fixed, so any other width is refused while the design is built.
   if (COUNT_WIDTH != 18) begin : g_width_check
      $error("gate_timer_unit: COUNT_WIDTH must be 18, the compare and byte layout assume it");
   end

   typedef enum logic [1:0] {
      GATE_OFF  = 2'b00,
      GATE_HIGH = 2'b01,
      GATE_LOW  = 2'b10
   } gate_state_type;

   function automatic logic div_tick(input logic [23:0] cnt, input logic [4:0] n);
      logic [23:0] mask;
      mask = (24'h000001 << n) - 24'h000001;
      div_tick = (cnt & mask) == mask;
   endfunction : div_tick

   // Registers.
   logic [7:0]             control_one;
   logic [7:0]             control_two;
   logic [7:0]             gate_period;
   logic [1:0]             system_mode;
   logic [17:0]            compare_value;
   logic                   compare_hold;
   logic [17:0]            counter;
   logic                   overflow_flag;
   logic                   clear_req;
   // Bus state.
   logic                   wr_pend;
   logic [7:0]             wr_idx;
   logic                   addr_ok;
   // Clocks and inputs.
   logic [23:0]            fc_div;
   logic [15:0]            fs_div;
   logic                   fs_sync1;
   logic                   fs_sync2;
   logic                   fs_prev;
   logic                   ext_sync1;
   logic                   ext_sync2;
   logic                   ext_prev;
   // Gate.
   gate_state_type         gate_state;
   logic [4:0]             gate_left;
   logic                   gate_prev;

   wire logic        running     = control_one[POS_RUN_LSB +: 2] == RUN_START;
   wire logic [1:0]  mode        = control_one[POS_MODE_LSB +: 2];
   wire logic [2:0]  clock_sel   = control_one[POS_CLOCK_SEL_LSB +: 3];
   wire logic        ext_edge    = control_two[POS_EXT_EDGE];
   wire logic [1:0]  gate_src    = control_two[POS_GATE_SRC_LSB +: 2];
   wire logic        gate_both   = control_two[POS_GATE_IRQ_EDGE];
   wire logic [1:0]  gate_clk    = control_two[POS_GATE_CLK_LSB +: 2];
   wire logic        slow_mode   = system_mode[POS_SLOW_MODE];
   wire logic        use_fs      = slow_mode | system_mode[POS_DIVIDER_SRC];
   wire logic        fs_edge     = fs_sync2 & ~fs_prev;
   wire logic        ext_fall    = ext_prev & ~ext_sync2;
   wire logic        ext_rise    = ~ext_prev & ext_sync2;
   wire logic        freq_mode   = running && mode == MODE_FREQUENCY;
   wire logic        count_mode  = running && mode == MODE_TIMER_EVENT;

   // Bus address phase.
   wire logic        ap_valid    = HSEL_I & HTRANS_I[1] & HREADY_I;
   wire logic [7:0]  ap_idx      = HADDR_I[9:2];
   wire logic        ap_in_range = HADDR_I[31:10] == 22'h000000;
   wire logic        wr_now      = wr_pend & addr_ok;
   wire logic [7:0]  wdata       = HWDATA_I[7:0];

   // Count clock selection.
   logic count_tick;
   always_comb begin
      case (clock_sel)
         3'h0:    count_tick = 1'b1;
         3'h1:    count_tick = fs_edge;
         3'h2:    count_tick = use_fs ? fs_edge & div_tick({8'h00, fs_div}, EXP_FS_15)
                                      : div_tick(fc_div, EXP_FC_23);
         3'h3:    count_tick = use_fs ? fs_edge & div_tick({8'h00, fs_div}, EXP_FS_5)
                                      : div_tick(fc_div, EXP_FC_13);
         3'h4:    count_tick = use_fs ? fs_edge & div_tick({8'h00, fs_div}, EXP_FS_3)
                                      : div_tick(fc_div, EXP_FC_11);
         3'h5:    count_tick = div_tick(fc_div, EXP_FC_7);
         3'h6:    count_tick = div_tick(fc_div, EXP_FC_3);
         3'h7:    count_tick = ext_fall;
         default: count_tick = 1'b0;
      endcase
   end

   // Gate clock: the reserved code never ticks, which holds the gate in its phase.
   logic gate_tick;
   always_comb begin
      if (gate_clk == GATE_CLK_RESERVED) begin
         gate_tick = 1'b0;
      end else if (use_fs) begin
         gate_tick = fs_edge & div_tick({8'h00, fs_div}, EXP_FS_4 + {3'h0, gate_clk});
      end else begin
         gate_tick = div_tick(fc_div, EXP_FC_12 + {3'h0, gate_clk});
      end
   end

   // The window gate as seen by the counter.
   wire logic gate_level = (gate_src == GATE_SRC_INTERNAL) ? gate_state == GATE_HIGH
                                                           : COMPANION_PULSE_I;
   wire logic gate_on    = freq_mode & gate_level;
   wire logic gate_fall  = gate_prev & ~gate_on;
   wire logic gate_rise  = ~gate_prev & gate_on;

   // Compare match on the value the counter is about to take.
   wire logic [17:0] counter_next = counter + 18'h00001;
   wire logic        slow_fc      = slow_mode && clock_sel == CLK_FC;
   wire logic        match_full   = counter_next == compare_value;
   wire logic        match_upper  = counter_next[17:SLOW_FC_IGNORED] == compare_value[17:SLOW_FC_IGNORED];
   wire logic        match        = ~compare_hold & (slow_fc ? match_upper : match_full);
   wire logic        freq_count   = gate_on & (ext_fall | (ext_edge & ext_rise));
   wire logic        inc          = count_mode ? count_tick : freq_count;
   wire logic        cmp_hit      = count_mode & count_tick & match;

   // Low clock and external count input synchronisers.
   always_ff @(posedge CLK_I or negedge RESETN_I) begin
      if (!RESETN_I) begin
         fs_sync1  <= 1'b0;
         fs_sync2  <= 1'b0;
         fs_prev   <= 1'b0;
         ext_sync1 <= 1'b0;
         ext_sync2 <= 1'b0;
         ext_prev  <= 1'b0;
      end else if (CE_I) begin
         fs_sync1  <= FS_CLK_I;
         fs_sync2  <= fs_sync1;
         fs_prev   <= fs_sync2;
         ext_sync1 <= EXT_COUNT_I;
         ext_sync2 <= ext_sync1;
         ext_prev  <= ext_sync2;
      end
   end

   // Prescalers for fc and fs.
   always_ff @(posedge CLK_I or negedge RESETN_I) begin
      if (!RESETN_I) begin
         fc_div <= 24'h000000;
         fs_div <= 16'h0000;
      end else if (CE_I) begin
         fc_div <= fc_div + 24'h000001;
         if (fs_edge) begin
            fs_div <= fs_div + 16'h0001;
         end
      end
   end

   // Internal window gate: a high phase of 16 - Ta ticks then a low phase of 16 - Tb ticks.
   always_ff @(posedge CLK_I or negedge RESETN_I) begin
      if (!RESETN_I) begin
         gate_state <= GATE_OFF;
         gate_left  <= 5'h00;
      end else if (CE_I) begin
         case (gate_state)
            GATE_OFF: begin
               if (freq_mode && gate_src == GATE_SRC_INTERNAL) begin
                  gate_state <= GATE_HIGH;
                  gate_left  <= GATE_PERIOD_BASE - {1'b0, gate_period[7:4]};
               end
            end
            GATE_HIGH: begin
               if (!freq_mode) begin
                  gate_state <= GATE_OFF;
               end else if (gate_tick && gate_left == 5'h01) begin
                  gate_state <= GATE_LOW;
                  gate_left  <= GATE_PERIOD_BASE - {1'b0, gate_period[3:0]};
               end else if (gate_tick) begin
                  gate_left <= gate_left - 5'h01;
               end
            end
            GATE_LOW: begin
               if (!freq_mode) begin
                  gate_state <= GATE_OFF;
               end else if (gate_tick && gate_left == 5'h01) begin
                  gate_state <= GATE_HIGH;
                  gate_left  <= GATE_PERIOD_BASE - {1'b0, gate_period[7:4]};
               end else if (gate_tick) begin
                  gate_left <= gate_left - 5'h01;
               end
            end
            default: begin
               gate_state <= GATE_OFF;
            end
         endcase
      end
   end

   // Gate edge tracking and the one-cycle interrupt request.
   always_ff @(posedge CLK_I or negedge RESETN_I) begin
      if (!RESETN_I) begin
         gate_prev   <= 1'b0;
         TIMER_IRQ_O <= 1'b0;
      end else if (CE_I) begin
         gate_prev   <= gate_on;
         TIMER_IRQ_O <= cmp_hit | gate_fall | (gate_both & gate_rise);
      end else begin
         TIMER_IRQ_O <= 1'b0;
      end
   end

   // Up-counter and overflow flag; a stop clears the count, a clear request clears both.
   always_ff @(posedge CLK_I or negedge RESETN_I) begin
      if (!RESETN_I) begin
         counter       <= 18'h00000;
         overflow_flag <= 1'b0;
      end else if (CE_I) begin
         if (!running || clear_req) begin
            counter <= 18'h00000;
         end else if (cmp_hit) begin
            counter <= 18'h00000;
         end else if (inc) begin
            counter <= counter_next;
         end
         // The wrap sets the flag even in a cycle in which software clears it.
         overflow_flag <= (overflow_flag & ~clear_req) | (running & inc & ~cmp_hit & (&counter));
      end
   end

   // Bus data phase tracking.
   always_ff @(posedge CLK_I or negedge RESETN_I) begin
      if (!RESETN_I) begin
         wr_pend     <= 1'b0;
         wr_idx      <= 8'h00;
         addr_ok     <= 1'b0;
         HREADYOUT_O <= 1'b1;
         HRESP_O     <= 1'b0;
      end else if (CE_I) begin
         wr_pend     <= ap_valid & HWRITE_I;
         wr_idx      <= ap_idx;
         addr_ok     <= ap_in_range;
         HREADYOUT_O <= 1'b1;
         HRESP_O     <= 1'b0;
      end
   end

   // Register writes.
   always_ff @(posedge CLK_I or negedge RESETN_I) begin
      if (!RESETN_I) begin
         control_one   <= RST_CONTROL_ONE;
         control_two   <= RST_CONTROL_TWO;
         gate_period   <= RST_GATE_PERIOD;
         system_mode   <= 2'h0;
         compare_value <= 18'h00001;
         compare_hold  <= 1'b0;
         clear_req     <= 1'b0;
      end else if (CE_I) begin
         clear_req <= 1'b0;
         if (wr_now) begin
            case (wr_idx)
               IDX_CONTROL_ONE: begin
                  control_one <= wdata;
                  clear_req   <= ~wdata[POS_CLEAR_CTRL];
               end
               IDX_CONTROL_TWO: begin
                  // Bit 0 has no function and is not stored.
                  control_two <= {wdata[7:1], 1'b0};
               end
               IDX_COMPARE_LOW: begin
                  compare_value[7:0] <= wdata;
                  compare_hold       <= 1'b1;
               end
               IDX_COMPARE_MID: begin
                  compare_value[15:8] <= wdata;
                  compare_hold        <= 1'b1;
               end
               IDX_COMPARE_HIGH: begin
                  compare_value[17:16] <= wdata[1:0];
                  compare_hold         <= 1'b0;
               end
               IDX_GATE_PERIOD: begin
                  gate_period <= wdata;
               end
               IDX_SYSTEM_MODE: begin
                  system_mode <= wdata[1:0];
               end
               default: begin
                  clear_req <= 1'b0;
               end
            endcase
         end
      end
   end

   // Read data; the compare addresses return the live count, which reads zero while stopped.
   logic [7:0] rd_byte;
   always_comb begin
      rd_byte = 8'h00;
      case (ap_idx)
         IDX_CONTROL_ONE:  rd_byte = control_one;
         IDX_CONTROL_TWO:  rd_byte = control_two;
         IDX_STATUS: begin
            rd_byte[POS_GATE_COUNTING] = gate_on;
            rd_byte[POS_OVERFLOW]      = overflow_flag;
         end
         IDX_COMPARE_LOW:  rd_byte = counter[7:0];
         IDX_COMPARE_MID:  rd_byte = counter[15:8];
         IDX_COMPARE_HIGH: rd_byte = {6'h00, counter[17:16]};
         IDX_GATE_PERIOD:  rd_byte = gate_period;
         IDX_SYSTEM_MODE:  rd_byte = {6'h00, system_mode};
         default:          rd_byte = 8'h00;
      endcase
   end

   always_ff @(posedge CLK_I or negedge RESETN_I) begin
      if (!RESETN_I) begin
         HRDATA_O <= 32'h00000000;
      end else if (CE_I && ap_valid && !HWRITE_I) begin
         HRDATA_O <= ap_in_range ? {24'h000000, rd_byte} : 32'h00000000;
      end
   end

   // Shared pin: companion pulse output routed out only while the route bit is clear.
   always_ff @(posedge CLK_I or negedge RESETN_I) begin
      if (!RESETN_I) begin
         SHARED_PIN_O    <= 1'b0;
         SHARED_PIN_OE_O <= 1'b0;
      end else if (CE_I) begin
         SHARED_PIN_O    <= COMPANION_PULSE_I;
         SHARED_PIN_OE_O <= ~control_two[POS_PWM_ROUTE_DIS];
      end
   end

endmodule : gate_timer_unit
